// ===== bench/tb.sv
// Self-checking testbench for the port clock gating block
`timescale 1ns/1ps
module tb;
  import spcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register access rows: direction, address, data, expected read, expected error
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] exp; logic err;} spcg_row_s;
  spcg_row_s rows[8] = '{
    '{1'b0, SLEEP_PORT_CLOCK_GATE_OFS, 32'h0, 32'h00000000, 1'b0},
    '{1'b0, RUN_PORT_CLOCK_GATE_OFS, 32'h0, 32'h00000000, 1'b0},
    '{1'b0, DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'h0, 32'h00000000, 1'b0},
    '{1'b0, RUN_CLOCK_CONFIG_OFS, 32'h0, 32'h00000000, 1'b0},
    '{1'b1, SLEEP_PORT_CLOCK_GATE_OFS, 32'hFFFFFFA5, 32'h0, 1'b0},
    '{1'b0, SLEEP_PORT_CLOCK_GATE_OFS, 32'h0, 32'h000000A5, 1'b0},
    '{1'b1, INT_STATUS_OFS, 32'h000000FF, 32'h0, 1'b0},
    '{1'b0, 12'h11C, 32'h0, 32'h00000000, 1'b1}
  };

  logic ref_clk = 1'b0; // 200 MHz
  logic rst = 1'b1; // Held for 8 cycles at the start
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, busFault, irq;
  logic sleepReq = 1'b0, deepSleepReq = 1'b0;
  logic [7:0] portAccess = 8'h00, portClkEn, portFault, seenFault;
  int mismatches = 0, checked = 0, busCount;

  always #2.5 ref_clk = ~ref_clk;

  spcg_top spcg_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepReq(sleepReq), .deepSleepReq(deepSleepReq), .portAccess(portAccess),
    .portClkEn(portClkEn), .portFault(portFault), .busFault(busFault), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict in one place; reached by the main sequence or the watchdog
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare one value and report a mismatch at once
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high, with a bounded wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // One-cycle access strobe, then gather faults over the next cycles
  task access(input logic [7:0] pat);
    @(posedge ref_clk);
    portAccess <= pat;
    @(posedge ref_clk);
    portAccess <= 8'h00;
    seenFault = 8'h00;
    busCount = 0;
    repeat (8) begin
      @(posedge ref_clk);
      seenFault |= portFault;
      if (busFault === 1'b1) busCount++;
    end
  endtask

  // Wait a settling span, long enough for sync stages and mode update
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Hang guard, well above the expected run length
  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: table rows first, then mode, fault and reset cases
  initial begin
    cyc(8);
    rst <= 1'b0;
    chk("clkEn after reset", 32'h0, {24'h0, portClkEn});
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("slverr", {31'h0, rows[i].err}, {31'h0, er});
      if (!rows[i].w) chk("read data", rows[i].exp, rd);
    end
    apb(1'b1, RUN_PORT_CLOCK_GATE_OFS, 32'h0000003C);
    cyc(6);
    chk("run enables", 32'h3C, {24'h0, portClkEn});
    sleepReq <= 1'b1;
    cyc(6);
    chk("sleep without auto", 32'h3C, {24'h0, portClkEn});
    apb(1'b1, RUN_CLOCK_CONFIG_OFS, 32'h00000001);
    cyc(6);
    chk("sleep enables", 32'hA5, {24'h0, portClkEn});
    apb(1'b1, DEEP_SLEEP_PORT_CLOCK_GATE_OFS, 32'h0000000F);
    deepSleepReq <= 1'b1;
    cyc(6);
    chk("deep enables", 32'h0F, {24'h0, portClkEn});
    sleepReq <= 1'b0;
    deepSleepReq <= 1'b0;
    cyc(6);
    chk("back to run", 32'h3C, {24'h0, portClkEn});
    apb(1'b1, INT_MASK_OFS, 32'h00000001);
    access(8'h01);
    chk("fault port A", 32'h01, {24'h0, seenFault});
    chk("bus fault cycles", 32'h1, busCount);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, INT_STATUS_OFS, 32'h0);
    chk("status read", 32'h01, rd);
    cyc(3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    access(8'h04);
    chk("enabled port", 32'h00, {24'h0, seenFault});
    access(8'h80);
    chk("fault port H", 32'h80, {24'h0, seenFault});
    chk("masked irq", 32'h0, {31'h0, irq});
    @(posedge ref_clk);
    rst <= 1'b1;
    cyc(2);
    chk("clkEn in reset", 32'h0, {24'h0, portClkEn});
    rst <= 1'b0;
    apb(1'b0, SLEEP_PORT_CLOCK_GATE_OFS, 32'h0);
    chk("sleep gate reset", 32'h0, rd);
    apb(1'b0, INT_STATUS_OFS, 32'h0);
    chk("status reset", 32'h0, rd);
    tally_and_finish;
  end
endmodule

// ===== hdl/spcg_pkg.sv
// Package of offsets, reset values, mode codes and the state record for the port clock gating block
package spcg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses from the system control base
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFS = 12'h060; // Holds the automatic gating select
  localparam logic [11:0] RUN_PORT_CLOCK_GATE_OFS = 12'h108; // Gating while running
  localparam logic [11:0] SLEEP_PORT_CLOCK_GATE_OFS = 12'h118; // Gating while asleep
  localparam logic [11:0] DEEP_SLEEP_PORT_CLOCK_GATE_OFS = 12'h128; // Gating in deep sleep
  localparam logic [11:0] INT_STATUS_OFS = 12'h130; // Sticky fault events, cleared by read
  localparam logic [11:0] INT_MASK_OFS = 12'h134; // Interrupt mask, same layout

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int PORT_COUNT = 8; // Ports A to H
  localparam int ACG_BIT = 0; // Automatic gating select in the run clock config
  localparam logic [7:0] GATE_RESET = 8'h00; // Every port unclocked
  localparam logic [7:0] MASK_RESET = 8'h00; // Interrupts masked
  localparam logic [7:0] STATUS_RESET = 8'h00; // No events pending
  localparam logic ACG_RESET = 1'b0; // Automatic gating off
  localparam logic [31:0] READ_ZERO = 32'h00000000; // Reserved and unmapped reads

  ////////////////////////////////////////////////////////////////////////////////
  // Power mode that selects the gating register
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP = 2'b10
  } spcg_mode_e;

  // Whole state of the block, registered in one process
  typedef struct packed {
    logic [7:0] runGate; // Run mode enables
    logic [7:0] sleepGate; // Sleep mode enables
    logic [7:0] deepGate; // Deep sleep mode enables
    logic auto_clock_gating_select; // Automatic gating select
    logic [7:0] mask; // Interrupt mask
    logic [7:0] status; // Sticky fault events
    logic [7:0] accS1; // Access strobe, first sync stage
    logic [7:0] accS2; // Access strobe, second sync stage
    logic slpS1; // Sleep request, first sync stage
    logic slpS2; // Sleep request, second sync stage
    logic dslS1; // Deep sleep request, first sync stage
    logic dslS2; // Deep sleep request, second sync stage
    spcg_mode_e mode; // Current power mode
    logic [7:0] clkEn; // Applied port clock enables
    logic [7:0] fault; // Per port fault pulse
    logic busFault; // Any port fault pulse
    logic pready; // APB ready
    logic pslverr; // APB error
    logic [31:0] prdata; // APB read data
    logic irq; // Interrupt level
  } spcg_state_s;

endpackage

// ===== hdl/spcg_top.sv
// Port clock gating block: run, sleep and deep sleep gating registers behind an APB slave
//
// Function
// - sleep gating register sits at 0x118
// - bit 7 port H down to bit 0 port A
// - set bit clocks its port
// - clear bit stops its port clock
// - access to unclocked port gives bus fault
// - all enables reset to zero
// - sleep register applies in sleep; others elsewhere
// - sleep registers used only with automatic gating
// - bits 31:8 read-only, read as zero
`timescale 1ns/1ps
module spcg_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave, same clock as the block
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power mode requests from the processor, asynchronous
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  // Port side: access strobes in, enables and faults out
  input wire logic [spcg_pkg::PORT_COUNT-1:0] portAccess,
  output logic [spcg_pkg::PORT_COUNT-1:0] portClkEn,
  output logic [spcg_pkg::PORT_COUNT-1:0] portFault,
  output logic busFault,
  output logic irq
);
  import spcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State and bus decode
  spcg_state_s st; // Registered state
  spcg_state_s next_st; // Next state
  logic apbAccess; // Access phase in progress
  logic apbDone; // Transfer completes at this edge
  logic [7:0] clearBits; // Status bits that a finishing read clears

  // Access phase: select and enable both high
  assign apbAccess = psel && penable;
  // A transfer completes at the edge where ready is already up
  assign apbDone = apbAccess && st.pready;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    clearBits = 8'h00;
    // Pins come from outside the clock domain: two stages before use
    // Only the second stage of each pair feeds any logic
    next_st.accS1 = portAccess;
    next_st.accS2 = st.accS1;
    next_st.slpS1 = sleepReq;
    next_st.slpS2 = st.slpS1;
    next_st.dslS1 = deepSleepReq;
    next_st.dslS2 = st.dslS1;

    // The mode is registered, so enables trail a pin change by four edges
    // Mode follows the requests only when automatic gating is selected
    if (!st.auto_clock_gating_select) begin
      next_st.mode = MODE_RUN;
    end else if (st.dslS2) begin
      next_st.mode = MODE_DEEP; // Deep sleep wins over plain sleep
    end else if (st.slpS2) begin
      next_st.mode = MODE_SLEEP;
    end else begin
      next_st.mode = MODE_RUN;
    end

    // Pick the register that gates the ports in the current mode
    // Trade-off: one extra cycle of latency buys glitch-free enables
    unique case (st.mode)
      MODE_RUN: begin
        next_st.clkEn = st.runGate;
      end
      MODE_SLEEP: begin
        next_st.clkEn = st.sleepGate;
      end
      MODE_DEEP: begin
        next_st.clkEn = st.deepGate;
      end
      default: begin
        next_st.clkEn = st.runGate; // Unused code falls back to running
      end
    endcase

    // An access to a port whose clock is off is answered with a fault
    // Limitation: an access right at an enable change is judged by the old setting
    next_st.fault = st.accS2 & ~st.clkEn;
    next_st.busFault = |(st.accS2 & ~st.clkEn);

    // APB: one wait state; data is captured when ready is raised
    // Decode and data are registered together, so a read never sees a half-decoded word
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (apbAccess && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.prdata = READ_ZERO; // Upper bits stay zero
      unique case (paddr)
        RUN_CLOCK_CONFIG_OFS: begin
          next_st.prdata[ACG_BIT] = st.auto_clock_gating_select;
        end
        RUN_PORT_CLOCK_GATE_OFS: begin
          next_st.prdata[7:0] = st.runGate;
        end
        SLEEP_PORT_CLOCK_GATE_OFS: begin
          next_st.prdata[7:0] = st.sleepGate;
        end
        DEEP_SLEEP_PORT_CLOCK_GATE_OFS: begin
          next_st.prdata[7:0] = st.deepGate;
        end
        INT_STATUS_OFS: begin
          next_st.prdata[7:0] = st.status;
        end
        INT_MASK_OFS: begin
          next_st.prdata[7:0] = st.mask;
        end
        default: begin
          next_st.pslverr = 1'b1; // Unmapped address
        end
      endcase
    end else if (apbAccess && st.pready) begin
      next_st.prdata = st.prdata; // Hold until released
    end

    // Writes take effect at the completing edge; bits 31:8 are dropped
    // A transfer answered with an error never writes
    if (apbDone && pwrite && !st.pslverr) begin
      unique case (paddr)
        RUN_CLOCK_CONFIG_OFS: begin
          next_st.auto_clock_gating_select = pwdata[ACG_BIT];
        end
        RUN_PORT_CLOCK_GATE_OFS: begin
          next_st.runGate = pwdata[7:0];
        end
        SLEEP_PORT_CLOCK_GATE_OFS: begin
          next_st.sleepGate = pwdata[7:0];
        end
        DEEP_SLEEP_PORT_CLOCK_GATE_OFS: begin
          next_st.deepGate = pwdata[7:0];
        end
        INT_MASK_OFS: begin
          next_st.mask = pwdata[7:0];
        end
        default: begin
          next_st.auto_clock_gating_select = st.auto_clock_gating_select; // Status is read-only
        end
      endcase
    end

    // Read clears only the bits that were actually returned, so an event
    // arriving between capture and completion survives
    if (apbDone && !pwrite && !st.pslverr && paddr == INT_STATUS_OFS) begin
      clearBits = st.prdata[7:0];
    end
    next_st.status = (st.status & ~clearBits) | st.fault; // Set wins
    next_st.irq = |(next_st.status & next_st.mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves every port unclocked
  // Fields are named again so the reset values stay tied to the package
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.runGate <= GATE_RESET;
      st.sleepGate <= GATE_RESET;
      st.deepGate <= GATE_RESET;
      st.auto_clock_gating_select <= ACG_RESET;
      st.mask <= MASK_RESET;
      st.status <= STATUS_RESET;
      st.mode <= MODE_RUN;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  // No output is combinational, so downstream timing starts at a flop
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign portClkEn = st.clkEn;
  assign portFault = st.fault;
  assign busFault = st.busFault;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  // All checks run on the single clock and pause while reset is high
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // A completed write lands in the sleep register
  AST_SLEEP_WRITE: assert property (
    apbDone && pwrite && paddr == SLEEP_PORT_CLOCK_GATE_OFS
    |=> st.sleepGate == $past(pwdata[7:0]))
    else $error("Sleep gate write lost");

  // Sleep register reads back in bits 7:0
  AST_BIT_MAP: assert property (
    apbDone && !pwrite && paddr == SLEEP_PORT_CLOCK_GATE_OFS
    |-> prdata == {24'h000000, st.sleepGate})
    else $error("Sleep gate read data wrong");

  // In sleep the enables follow the sleep register
  AST_CLK_ON: assert property (
    st.mode == MODE_SLEEP |=> portClkEn == $past(st.sleepGate))
    else $error("Sleep enables not applied");

  // A cleared bit keeps its port clock off
  AST_CLK_OFF: assert property (
    st.mode == MODE_SLEEP |=> (portClkEn & ~$past(st.sleepGate)) == 8'h00)
    else $error("Port clock on with bit clear");

  // Access to an unclocked port faults next cycle
  AST_FAULT: assert property (
    |(st.accS2 & ~st.clkEn) |=> busFault && portFault == $past(st.accS2 & ~st.clkEn))
    else $error("Missing bus fault");

  // Just after reset every enable is zero
  AST_RESET: assert property (
    $fell(rst)
    |-> st.runGate == 8'h00 && st.sleepGate == 8'h00 && st.deepGate == 8'h00 && portClkEn == 8'h00)
    else $error("Enables not zero after reset");

  // Deep sleep uses its own register
  AST_DEEP_SEL: assert property (
    st.mode == MODE_DEEP |=> portClkEn == $past(st.deepGate))
    else $error("Deep sleep enables not applied");

  // Without automatic gating the mode stays run
  AST_ACG_OFF: assert property (
    !st.auto_clock_gating_select |=> st.mode == MODE_RUN)
    else $error("Sleep mode without auto gating");

  // Reserved bits read zero on every read
  AST_RSVD: assert property (
    pready |-> prdata[31:8] == 24'h000000)
    else $error("Reserved bits not zero");

  // Run mode uses the run register
  AST_RUN_SEL: assert property (
    st.mode == MODE_RUN |=> portClkEn == $past(st.runGate))
    else $error("Run enables not applied");

  // Interrupt follows unmasked status
  AST_IRQ: assert property (
    irq == |(st.status & st.mask))
    else $error("Interrupt does not follow unmasked status");

  // One wait state: ready is a single-cycle pulse per transfer
  AST_READY_PULSE: assert property (
    pready |=> !pready)
    else $error("Ready held longer than one cycle");

  // Ready answers one cycle after the first access edge
  AST_READY_TIME: assert property (
    psel && penable && !pready |=> pready)
    else $error("Ready not raised after access edge");

  // Unmapped address answers with an error and zero data
  AST_UNMAPPED: assert property (
    pready && pslverr |-> prdata == READ_ZERO)
    else $error("Unmapped read data not zero");

  // A fault event always lands in its sticky status bit
  AST_STATUS_SET: assert property (
    |st.fault |=> (st.status & $past(st.fault)) == $past(st.fault))
    else $error("Fault event lost from status");

  // A status read clears the returned bits unless a new event hits them
  AST_STATUS_CLEAR: assert property (
    apbDone && !pwrite && paddr == INT_STATUS_OFS && !st.pslverr
    |=> (st.status & $past(st.prdata[7:0] & ~st.fault)) == 8'h00)
    else $error("Status not cleared by read");

  // Status is read-only: a write leaves it unchanged but for new events
  AST_STATUS_RO: assert property (
    apbDone && pwrite && paddr == INT_STATUS_OFS
    |=> st.status == ($past(st.status) | $past(st.fault)))
    else $error("Status changed by write");

  // Deep sleep request wins over sleep when gating is automatic
  AST_DEEP_WINS: assert property (
    st.auto_clock_gating_select && st.dslS2 |=> st.mode == MODE_DEEP)
    else $error("Deep sleep request ignored");

  // Main scenarios worth seeing at least once
  COV_SLEEP: cover property (st.mode == MODE_SLEEP ##1 portClkEn != 8'h00);
  COV_DEEP: cover property (st.mode == MODE_DEEP);
  COV_FAULT: cover property (busFault ##[1:20] irq);
  COV_SLVERR: cover property (pready && pslverr);
  COV_STATUS_CLR: cover property (apbDone && !pwrite && paddr == INT_STATUS_OFS);

endmodule
